//--- rtl/isx_pkg.sv
// Package of constants for the indexed stack instruction executor
//
// Contract
// - Indexed move: two words, two cycles
// - Addresses are frame pointer plus offsets
// - Move addresses span whole 12-bit space
// - Indirect-register source reads as zero
// - Indirect-register destination suppresses the write
// - Push stores literal at frame pointer
// - Push then decrements frame pointer by one
// - Push is one word, one cycle
// - Pointer subtract: selectors 0-2, no flags
// - Subtract-and-return subtracts, then pops program counter
// - Subtract-and-return takes two cycles
// - Selector 11 means subtract-and-return on frame pointer
package isx_pkg;
    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PC_W = 21;
    // Opcode upper bytes
    localparam logic [7:0] OP_MOVE_HI = 8'hEB;
    localparam logic [7:0] OP_SUB_HI = 8'hE9;
    localparam logic [7:0] OP_PUSH_HI = 8'hFA;
    localparam logic [3:0] OP_SECOND_NIB = 4'hF;
    // Field positions
    localparam int MOVE_SEL_BIT = 7;
    localparam int SEL_LSB = 6;
    localparam logic [1:0] SEL_RETURN = 2'h3;
    localparam logic [1:0] SEL_FRAME = 2'h2;
    // Indirect addressing register addresses (top of data space)
    localparam logic [ADDR_W-1:0] INDIRECT_BASE0 = 12'hFEB;
    localparam logic [ADDR_W-1:0] INDIRECT_BASE1 = 12'hFE3;
    localparam logic [ADDR_W-1:0] INDIRECT_BASE2 = 12'hFDB;
    localparam logic [ADDR_W-1:0] INDIRECT_SPAN = 12'h005;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
    // States
    typedef enum logic [2:0] {
        ISX_IDLE = 3'b001,
        ISX_MOVE2 = 3'b010,
        ISX_RET2 = 3'b100
    } isx_state_e;
endpackage

//--- rtl/isx_indirect_detect.sv
// Detector of indirect addressing register addresses
`timescale 1ns/100ps
`default_nettype none
module isx_indirect_detect #(
    parameter int ADDR_W = 12
) (
    input wire logic [ADDR_W-1:0] addr,
    output logic hit
);
    // Windows are fixed at the package width
    if (ADDR_W != isx_pkg::ADDR_W) begin : g_chk
        $error("isx_indirect_detect needs the package address width");
    end
    // Each pointer owns five indirect registers starting at its base
    function automatic logic in_group(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        in_group = (a >= b) && (a < b + isx_pkg::INDIRECT_SPAN);
    endfunction
    assign hit = in_group(addr, isx_pkg::INDIRECT_BASE0)
               | in_group(addr, isx_pkg::INDIRECT_BASE1)
               | in_group(addr, isx_pkg::INDIRECT_BASE2);
endmodule
`default_nettype wire

//--- rtl/isx_exec.sv
// Execute unit for indexed move, push literal and pointer subtract instructions
`timescale 1ns/100ps
`default_nettype none
module isx_exec #(
    parameter int ADDR_W = isx_pkg::ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] mem_rdata,
    input wire logic [isx_pkg::PC_W-1:0] return_stack_top,
    output logic [ADDR_W-1:0] mem_raddr,
    output logic [ADDR_W-1:0] mem_waddr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic pc_load,
    output logic [isx_pkg::PC_W-1:0] pc_value,
    output logic stack_pop,
    output logic busy,
    output logic [ADDR_W-1:0] ptr0,
    output logic [ADDR_W-1:0] ptr1,
    output logic [ADDR_W-1:0] frame_pointer
);
    if (ADDR_W != 12) begin : g_chk
        $error("isx_exec supports a 12-bit data space only");
    end

    isx_pkg::isx_state_e state;
    isx_pkg::isx_state_e next_state;
    logic src_zero; // Source hit an indirect register

    // Decode of the first word
    wire logic [7:0] op_hi = instr_word[15:8];
    wire logic [1:0] sel = instr_word[isx_pkg::SEL_LSB +: 2];
    wire logic [ADDR_W-1:0] lit6 = {6'h00, instr_word[5:0]};
    wire logic [ADDR_W-1:0] off7 = {5'h00, instr_word[6:0]};
    wire logic idle = (state == isx_pkg::ISX_IDLE);
    wire logic dec_move = idle && instr_valid && op_hi == isx_pkg::OP_MOVE_HI
                          && instr_word[isx_pkg::MOVE_SEL_BIT];
    wire logic dec_push = idle && instr_valid && op_hi == isx_pkg::OP_PUSH_HI;
    wire logic dec_sub = idle && instr_valid && op_hi == isx_pkg::OP_SUB_HI;
    wire logic dec_ret = dec_sub && sel == isx_pkg::SEL_RETURN;
    wire logic dec_fsub = dec_sub && sel != isx_pkg::SEL_RETURN;
    wire logic second_ok = instr_valid && instr_word[15:12] == isx_pkg::OP_SECOND_NIB;

    // source and destination wrap in twelve bits
    wire logic [ADDR_W-1:0] src_addr = frame_pointer + off7;
    wire logic [ADDR_W-1:0] dst_addr = frame_pointer + off7;
    wire logic dst_indirect;
    wire logic src_indirect;
    isx_indirect_detect #(.ADDR_W(ADDR_W)) u_src (.addr(src_addr), .hit(src_indirect));
    isx_indirect_detect #(.ADDR_W(ADDR_W)) u_dst (.addr(dst_addr), .hit(dst_indirect));
    wire logic move_wr = (state == isx_pkg::ISX_MOVE2) && second_ok;

    // Next state selection
    always_comb begin
        next_state = state;
        unique case (state)
            isx_pkg::ISX_IDLE: begin
                if (dec_move) begin
                    next_state = isx_pkg::ISX_MOVE2;
                end else if (dec_ret) begin
                    next_state = isx_pkg::ISX_RET2;
                end
            end
            isx_pkg::ISX_MOVE2: begin
                if (instr_valid) begin
                    next_state = isx_pkg::ISX_IDLE;
                end
            end
            isx_pkg::ISX_RET2: next_state = isx_pkg::ISX_IDLE;
            default: next_state = isx_pkg::ISX_IDLE;
        endcase
    end

    // State register and move latch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= isx_pkg::ISX_IDLE;
            src_zero <= 1'b0;
        end else begin
            state <= next_state;
            if (dec_move) begin
                src_zero <= src_indirect;
            end
        end
    end

    // Pointer updates, no status flags touched
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr0 <= isx_pkg::PTR_RESET;
            ptr1 <= isx_pkg::PTR_RESET;
            frame_pointer <= isx_pkg::PTR_RESET;
        end else begin
            if (dec_fsub && sel == 2'h0) begin
                ptr0 <= ptr0 - lit6;
            end
            if (dec_fsub && sel == 2'h1) begin
                ptr1 <= ptr1 - lit6;
            end
            if ((dec_fsub && sel == isx_pkg::SEL_FRAME) || dec_ret) begin
                frame_pointer <= frame_pointer - lit6;
            end else if (dec_push) begin
                frame_pointer <= frame_pointer - 12'h001;
            end
        end
    end

    // Memory, program counter and stack outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_raddr <= isx_pkg::PTR_RESET;
            mem_waddr <= isx_pkg::PTR_RESET;
            mem_wdata <= isx_pkg::ZERO_DATA;
            mem_we <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= '0;
            stack_pop <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= (next_state != isx_pkg::ISX_IDLE);
            mem_we <= 1'b0;
            pc_load <= 1'b0;
            stack_pop <= 1'b0;
            if (dec_move) begin
                mem_raddr <= src_addr;
            end
            if (dec_push) begin
                mem_waddr <= frame_pointer;
                mem_wdata <= instr_word[7:0];
                mem_we <= 1'b1;
            end else if (move_wr) begin
                mem_waddr <= dst_addr;
                mem_wdata <= src_zero ? isx_pkg::ZERO_DATA : mem_rdata;
                mem_we <= !dst_indirect;
            end
            if (dec_ret) begin
                pc_load <= 1'b1;
                pc_value <= return_stack_top;
                stack_pop <= 1'b1;
            end
        end
    end

    // Push writes the literal at the pre-decrement pointer
    property p_push_store;
        @(posedge clk_sys) disable iff (rst)
        dec_push |=> mem_we && mem_waddr == $past(frame_pointer)
                     && frame_pointer == $past(frame_pointer) - 12'h001;
    endproperty
    a_push_store: assert property (p_push_store) else $error("push store wrong");

    sequence s_ret_start;
        dec_ret;
    endsequence
    sequence s_ret_tail;
        pc_load && stack_pop ##1 !pc_load && idle;
    endsequence
    property p_ret_two;
        @(posedge clk_sys) disable iff (rst)
        s_ret_start |=> s_ret_tail;
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return timing wrong");

    property p_move_two;
        @(posedge clk_sys) disable iff (rst)
        dec_move ##1 second_ok |=> idle;
    endproperty
    a_move_two: assert property (p_move_two) else $error("move length wrong");

    property p_dst_suppress;
        @(posedge clk_sys) disable iff (rst)
        move_wr && dst_indirect |=> !mem_we;
    endproperty
    a_dst_suppress: assert property (p_dst_suppress) else $error("write not suppressed");

    property p_src_zero;
        @(posedge clk_sys) disable iff (rst)
        move_wr && src_zero && !dst_indirect |=> mem_we && mem_wdata == 8'h00;
    endproperty
    a_src_zero: assert property (p_src_zero) else $error("indirect source not zero");

    property p_sub_ptr0;
        @(posedge clk_sys) disable iff (rst)
        dec_fsub && sel == 2'h0 |=> ptr0 == $past(ptr0) - $past(lit6);
    endproperty
    a_sub_ptr0: assert property (p_sub_ptr0) else $error("pointer subtract wrong");

    property p_ret_frame;
        @(posedge clk_sys) disable iff (rst)
        dec_ret |=> frame_pointer == $past(frame_pointer) - $past(lit6)
                    && pc_value == $past(return_stack_top);
    endproperty
    a_ret_frame: assert property (p_ret_frame) else $error("return update wrong");

    property p_move_addr;
        @(posedge clk_sys) disable iff (rst)
        dec_move |=> mem_raddr == $past(frame_pointer) + $past(off7);
    endproperty
    a_move_addr: assert property (p_move_addr) else $error("source address wrong");

    // Push hands its literal to memory unchanged
    property p_push_data;
        @(posedge clk_sys) disable iff (rst)
        dec_push |=> mem_wdata == $past(instr_word[7:0]);
    endproperty
    a_push_data: assert property (p_push_data) else $error("push data wrong");

    // Selector one moves only the second pointer
    property p_sub_ptr1;
        @(posedge clk_sys) disable iff (rst)
        dec_fsub && sel == 2'h1 |=> ptr1 == $past(ptr1) - $past(lit6) && $stable(ptr0);
    endproperty
    a_sub_ptr1: assert property (p_sub_ptr1) else $error("second pointer wrong");

    // The dead cycle of a return writes nothing and keeps the frame pointer
    property p_ret_dead;
        @(posedge clk_sys) disable iff (rst)
        state == isx_pkg::ISX_RET2 |=> !mem_we && !pc_load && $stable(frame_pointer);
    endproperty
    a_ret_dead: assert property (p_ret_dead) else $error("return dead cycle busy");
endmodule
`default_nettype wire

//--- dv/isx_mem_model.sv
// Data memory model on the far side of the executor
`timescale 1ns/100ps
`default_nettype none
module isx_mem_model (
    input wire logic clk_sys,
    input wire logic [11:0] mem_raddr,
    input wire logic [11:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    output logic [7:0] mem_rdata
);
    // Byte array seeded with an address pattern
    logic [7:0] mem [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    // Read data follows the source address at once
    assign mem_rdata = mem[mem_raddr];
    // Store on the write pulse
    always @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Random and corner bench for the indexed stack executor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic instr_valid = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    logic [20:0] return_stack_top = 21'h000000;
    logic [7:0] mem_rdata, mem_wdata;
    logic [11:0] mem_raddr, mem_waddr, ptr0, ptr1, frame_pointer, fp, p0, p1;
    logic mem_we, pc_load, stack_pop, busy;
    logic [20:0] pc_value;
    logic [7:0] sh [4096];
    logic [31:0] rs = 32'd41695;
    logic [31:0] corner [8] = '{32'h7700, 32'h2009, 32'h01110C02, 32'h01042002,
        32'h017F7F02, 32'h3F0D, 32'h1, 32'h3F05};
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #2 clk_sys = ~clk_sys;
    isx_exec DUT (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .mem_rdata(mem_rdata), .return_stack_top(return_stack_top),
        .mem_raddr(mem_raddr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop), .busy(busy),
        .ptr0(ptr0), .ptr1(ptr1), .frame_pointer(frame_pointer));
    isx_mem_model MEM (.clk_sys(clk_sys), .mem_raddr(mem_raddr), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
    // Repeatable random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Indirect register windows at the top of data space
    function automatic logic ind(input logic [11:0] a);
        return 12'(a - isx_pkg::INDIRECT_BASE0) < isx_pkg::INDIRECT_SPAN
            || 12'(a - isx_pkg::INDIRECT_BASE1) < isx_pkg::INDIRECT_SPAN
            || 12'(a - isx_pkg::INDIRECT_BASE2) < isx_pkg::INDIRECT_SPAN;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One word presented for one edge, results sampled just after
    task automatic issue(input logic [15:0] w);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr_word <= w;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
    endtask
    // Op picked by bits 1:0, fields from the rest
    task automatic run_op(input logic [31:0] r);
        logic [11:0] a, d;
        logic we;
        logic ret;
        a = fp + 12'(r[14:8]);
        d = fp + 12'(r[22:16]);
        we = r[26:24] != 3'h0 && !ind(d);
        ret = r[1:0] == 2'h1 && r[3:2] == 2'h3;
        if (r[1:0] == 2'h0) begin
            issue({isx_pkg::OP_PUSH_HI, r[15:8]});
            chk(mem_we, 1'h1);
            chk(mem_waddr, fp);
            chk(mem_wdata, r[15:8]);
            sh[fp] = r[15:8];
            fp = fp - 12'h001;
            chk(frame_pointer, fp);
        end else if (r[1:0] == 2'h1) begin
            if (ret) begin
                // Return word, then a push offered in its dead cycle
                @(posedge clk_sys);
                instr_valid <= 1'h1;
                instr_word <= {isx_pkg::OP_SUB_HI, r[3:2], r[13:8]};
                @(posedge clk_sys);
                instr_word <= {isx_pkg::OP_PUSH_HI, 8'hA5};
                #1;
            end else begin
                issue({isx_pkg::OP_SUB_HI, r[3:2], r[13:8]});
            end
            if (r[3:2] == 2'h0) p0 = p0 - 12'(r[13:8]);
            else if (r[3:2] == 2'h1) p1 = p1 - 12'(r[13:8]);
            else fp = fp - 12'(r[13:8]);
            chk(ptr0, p0);
            chk(ptr1, p1);
            chk(frame_pointer, fp);
            chk({pc_load, stack_pop, busy}, {3{ret}});
            if (ret) begin
                chk(pc_value, return_stack_top);
                @(posedge clk_sys);
                instr_valid <= 1'h0;
                #1;
                chk({busy, mem_we, pc_load, frame_pointer}, {3'h0, fp});
            end
        end else begin
            issue({isx_pkg::OP_MOVE_HI, 1'h1, r[14:8]});
            chk({busy, mem_we, mem_raddr}, {2'h2, a});
            // The memory model has no counter or stack-top bytes to hit
            issue({r[26:24] == 3'h0 ? 4'hE : 4'hF, r[31:27], r[22:16]});
            chk(mem_we, we);
            if (we) begin
                chk(mem_waddr, d);
                chk(mem_wdata, ind(a) ? 8'h00 : sh[a]);
                sh[d] = ind(a) ? 8'h00 : sh[a];
            end
            chk(busy, 1'h0);
        end
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        for (int i = 0; i < 4096; i++) begin
            sh[i] = 8'(i) ^ 8'h5A;
        end
        {fp, p0, p1} = 36'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        #1;
        chk({busy, frame_pointer, ptr0, ptr1}, 37'h0);
        for (int i = 0; i < 8; i++) begin
            run_op(corner[i]);
        end
        // Second reset in mid-run clears every pointer and pulse
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        #1;
        chk({busy, mem_we, pc_load, stack_pop, frame_pointer, ptr0, ptr1}, 40'h0);
        {fp, p0, p1} = 36'h0;
        for (int i = 0; i < 400; i++) begin
            rs = xs(rs);
            @(posedge clk_sys);
            return_stack_top <= rs[31:11];
            run_op(rs);
        end
        conclude();
    end
endmodule
`default_nettype wire
